// ===== core/aohp_pkg.sv
// Shared constants for the angle output hold port and its host
package aohp_pkg;

  // Clock
  localparam real CLK_PERIOD_NS = 25.0;

  // Device timing, in printed units
  localparam real BUSY_PULSE_US  = 0.4;
  localparam real BUSY_MAX_US    = 1.0;
  localparam real COUNT_DELAY_NS = 50.0;
  localparam real DATA_VALID_US  = 0.2;
  localparam real EN_VALID_NS    = 150.0;
  localparam real EN_RELEASE_NS  = 100.0;

  // Host timing, in printed units
  localparam real HOLD_SETUP_NS  = 500.0;
  localparam real EN_LEAD_NS     = 150.0;
  localparam real EN_DWELL_NS    = 150.0;
  localparam real BUS_FREE_NS    = 100.0;
  localparam real HOLD_HIGH_US   = 1.0;

  // Cycle counts: least times round up, longest times round down
  localparam logic [5:0] BUSY_CYC  = 6'(int'($ceil(BUSY_PULSE_US * 1000.0 / CLK_PERIOD_NS)));
  localparam logic [5:0] CHG_CYC   = 6'(int'($ceil(COUNT_DELAY_NS / CLK_PERIOD_NS)));
  localparam logic [5:0] VALID_CYC = 6'(int'($floor(DATA_VALID_US * 1000.0 / CLK_PERIOD_NS)));
  localparam logic [5:0] SETUP_CYC = 6'(int'($ceil(HOLD_SETUP_NS / CLK_PERIOD_NS)));
  localparam logic [5:0] LEAD_CYC  = 6'(int'($ceil(EN_LEAD_NS / CLK_PERIOD_NS)));
  localparam logic [5:0] DWELL_MIN = 6'(int'($ceil(EN_DWELL_NS / CLK_PERIOD_NS)));
  localparam logic [5:0] FREE_CYC  = 6'(int'($ceil(BUS_FREE_NS / CLK_PERIOD_NS)));
  localparam logic [5:0] HIGH_CYC  = 6'(int'($ceil(HOLD_HIGH_US * 1000.0 / CLK_PERIOD_NS)));
  // First read must satisfy both the enable dwell and the hold setup
  localparam logic [5:0] DWELL_CYC = (SETUP_CYC - LEAD_CYC > DWELL_MIN) ? SETUP_CYC - LEAD_CYC : DWELL_MIN;

  // Resolution select codes
  localparam logic [1:0] RES_10 = 2'h0;
  localparam logic [1:0] RES_12 = 2'h1;
  localparam logic [1:0] RES_14 = 2'h2;
  localparam logic [1:0] RES_16 = 2'h3;

  // Reset values
  localparam logic [15:0] ANGLE_RST = 16'h0000;
  localparam logic [1:0]  RES_RST   = RES_16;

endpackage : aohp_pkg

// ===== core/aohp_link_if.sv
// Pin level link between the angle port and its host
`timescale 1ns/100ps
interface aohp_link_if;
  // Host driven controls
  logic       hold_output_latch_n;
  logic       upper_en_drv;
  logic       upper_en_oe;
  logic       lower_en_drv;
  logic       lower_en_oe;
  // Enables as the device sees them, pulled up when undriven
  logic       upper_byte_enable_n;
  logic       lower_byte_enable_n;
  // Device driven pins
  logic       update_pulse;
  logic [7:0] upper_dat;
  logic       upper_oe;
  logic [7:0] lower_dat;
  logic       lower_oe;
  // Bus levels as the host sees them; an undriven bus reads zero
  logic [7:0] bus_hi;
  logic [7:0] bus_lo;
  logic [7:0] bus8;

  assign upper_byte_enable_n = upper_en_oe ? upper_en_drv : 1'b1;
  assign lower_byte_enable_n = lower_en_oe ? lower_en_drv : 1'b1;
  assign bus_hi = upper_oe ? upper_dat : 8'h00;
  assign bus_lo = lower_oe ? lower_dat : 8'h00;
  assign bus8   = upper_oe ? upper_dat : bus_lo;

  modport dev (
    input  hold_output_latch_n, upper_byte_enable_n, lower_byte_enable_n,
    output update_pulse, upper_dat, upper_oe, lower_dat, lower_oe
  );
  modport host (
    output hold_output_latch_n, upper_en_drv, upper_en_oe, lower_en_drv, lower_en_oe,
    input  update_pulse, bus_hi, bus_lo, bus8
  );
endinterface : aohp_link_if

// ===== core/aohp_port.sv
// Device end: tracking counter, hold latch and byte-wide output drivers
`timescale 1ns/100ps
module aohp_port (
  // Clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // Tracking loop side
  input  wire logic        step_req_in,
  input  wire logic        step_up_in,
  input  wire logic [1:0]  res_sel_in,
  // Status
  output logic      [15:0] angle_out,
  output logic      [1:0]  res_out,
  // Link pins
  aohp_link_if.dev         lk
);

  typedef struct packed {
    // Tracking counter, frozen word and resolution in force
    logic [15:0] count;
    logic [15:0] held;
    logic [1:0]  res;
    // Update pulse timing
    logic        busy;
    logic [5:0]  bcnt;
    logic        dir;
    logic        inh_at_start;
    // Output lanes
    logic [7:0]  hi_dat;
    logic        hi_oe;
    logic [7:0]  lo_dat;
    logic        lo_oe;
  } aohp_dev_state_t;

  aohp_dev_state_t st;
  aohp_dev_state_t next_st;
  logic            load;

  // Decoded view of the current state
  logic            take_step;
  logic            hold_open;
  logic            at_change;
  logic            at_valid;
  logic            at_last;
  logic     [15:0] stepped;
  logic      [1:0] lane_en_n;
  logic            lane_oe [2];
  logic      [7:0] lane_dat [2];

  // Weight of one LSB at the given resolution
  function automatic logic [15:0] res_step(input logic [1:0] r);
    unique case (r)
      aohp_pkg::RES_10: res_step = 16'h0040;
      aohp_pkg::RES_12: res_step = 16'h0010;
      aohp_pkg::RES_14: res_step = 16'h0004;
      aohp_pkg::RES_16: res_step = 16'h0001;
    endcase
  endfunction : res_step

  // Bits that exist at the given resolution
  function automatic logic [15:0] res_mask(input logic [1:0] r);
    res_mask = ~(res_step(r) - 16'h0001);
  endfunction : res_mask

  // Counter value one step away, in the requested direction
  function automatic logic [15:0] step_count(
    input logic [15:0] c,
    input logic        up,
    input logic [1:0]  r
  );
    if (up) begin
      step_count = c + res_step(r);
    end else begin
      step_count = c - res_step(r);
    end
  endfunction : step_count

  // True on the pulse cycle whose count equals the mark
  function automatic logic at_mark(
    input logic       busy,
    input logic [5:0] cnt,
    input logic [5:0] mark
  );
    at_mark = busy && (cnt == mark);
  endfunction : at_mark

  // Pulse phase marks; the counter moves a little after the pulse rises,
  // so a hold that lands on the rising edge sees the old word, never a
  // half-counted one
  assign at_change = at_mark(st.busy, st.bcnt, aohp_pkg::CHG_CYC);
  assign at_valid  = at_mark(st.busy, st.bcnt, aohp_pkg::VALID_CYC);
  assign at_last   = at_mark(st.busy, st.bcnt, aohp_pkg::BUSY_CYC - 6'h01);
  assign stepped   = step_count(st.count, st.dir, st.res);

  // Steps are taken only between pulses; a request during a pulse is dropped
  assign take_step = step_req_in && !st.busy;

  // Latch gate: open only between pulses with the hold released; a pulse
  // always closes it, whatever the hold does
  assign hold_open = !st.busy && lk.hold_output_latch_n;

  // Enables per lane; lane 1 is the upper byte, lane 0 the lower
  assign lane_en_n = {lk.upper_byte_enable_n, lk.lower_byte_enable_n};

  // A lane drives its byte one cycle after its enable falls and parks at
  // zero otherwise, so an idle lane never shows a stale byte
  for (genvar g = 0; g < 2; g++) begin : g_lane
    assign lane_oe[g]  = !lane_en_n[g];
    assign lane_dat[g] = lane_en_n[g] ? 8'h00 : st.held[8*g +: 8];
  end

  always_comb begin
    next_st = st;
    load    = 1'b0;

    // Tracking counter and update pulse
    if (st.busy) begin
      next_st.bcnt = st.bcnt + 6'h01;
    end
    if (at_change) begin
      next_st.count = stepped;
    end
    // Resolution is picked up as the pulse ends, never mid-count
    if (at_last) begin
      next_st.busy = 1'b0;
      next_st.res  = res_sel_in;
    end

    // A new pulse remembers whether the hold was already applied
    if (take_step) begin
      next_st.busy         = 1'b1;
      next_st.bcnt         = 6'h00;
      next_st.dir          = step_up_in;
      next_st.inh_at_start = !lk.hold_output_latch_n;
    end

    // Hold latch: transparent between pulses unless held; inside a pulse it
    // loads only at the valid mark and at the end, and not at all when the
    // hold was already applied as the pulse began
    if (hold_open) begin
      load = 1'b1;
    end
    if ((at_valid || at_last) && !st.inh_at_start) begin
      load = 1'b1;
    end

    // Mask with the resolution that will be in force, so a resolution
    // change never alters a word already frozen
    if (load) begin
      next_st.held = st.count & res_mask(next_st.res);
    end

    // Drivers follow the enables one cycle later; idle lanes read zero
    next_st.hi_oe  = lane_oe[1];
    next_st.hi_dat = lane_dat[1];
    next_st.lo_oe  = lane_oe[0];
    next_st.lo_dat = lane_dat[0];
  end

  // Clock enable low freezes every bit of state, the lanes included
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      // Reset parks both lanes idle and the word at its reset value
      st.count        <= aohp_pkg::ANGLE_RST;
      st.held         <= aohp_pkg::ANGLE_RST;
      st.res          <= aohp_pkg::RES_RST;
      st.busy         <= 1'b0;
      st.bcnt         <= 6'h00;
      st.dir          <= 1'b0;
      st.inh_at_start <= 1'b0;
      st.hi_dat       <= 8'h00;
      st.hi_oe        <= 1'b0;
      st.lo_dat       <= 8'h00;
      st.lo_oe        <= 1'b0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  // Every output is a field of the state register
  assign angle_out       = st.count;
  assign res_out         = st.res;
  assign lk.update_pulse = st.busy;
  assign lk.upper_dat    = st.hi_dat;
  assign lk.upper_oe     = st.hi_oe;
  assign lk.lower_dat    = st.lo_dat;
  assign lk.lower_oe     = st.lo_oe;

endmodule : aohp_port

// ===== core/aohp_host.sv
// Host end: holds the latch, reads both bytes in one or two accesses, releases the bus
`timescale 1ns/100ps
module aohp_host (
  // Clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // Read request
  input  wire logic        read_req_in,
  input  wire logic        bus16_in,
  // Read result
  output logic      [15:0] word_out,
  output logic             word_valid_out,
  output logic             busy_out,
  // Link pins
  aohp_link_if.host        lk
);

  typedef enum logic [2:0] {
    HS_IDLE, HS_LEAD, HS_DWELL, HS_LOW, HS_FREE, HS_REFRESH
  } aohp_hstate_t;

  typedef struct packed {
    aohp_hstate_t state;
    logic [5:0]   cnt;
    logic         wide;
    logic         hold_n;
    logic         hi_on;
    logic         lo_on;
    logic [15:0]  word;
    logic         valid;
    logic         busy;
  } aohp_host_state_t;

  aohp_host_state_t st;
  aohp_host_state_t next_st;

  always_comb begin
    next_st       = st;
    next_st.valid = 1'b0;
    next_st.cnt   = st.cnt + 6'h01;
    unique case (st.state)
      HS_IDLE: begin
        next_st.cnt = 6'h00;
        if (read_req_in) begin
          next_st.state  = HS_LEAD;
          next_st.hold_n = 1'b0;
          next_st.wide   = bus16_in;
          next_st.busy   = 1'b1;
        end
      end
      HS_LEAD: begin
        if (st.cnt == aohp_pkg::LEAD_CYC - 6'h01) begin
          next_st.state = HS_DWELL;
          next_st.cnt   = 6'h00;
          next_st.hi_on = 1'b1;
          next_st.lo_on = st.wide;
        end
      end
      HS_DWELL: begin
        // Covers both the enable dwell and the full hold setup
        if (st.cnt == aohp_pkg::DWELL_CYC - 6'h01) begin
          next_st.cnt = 6'h00;
          if (st.wide) begin
            next_st.word  = {lk.bus_hi, lk.bus_lo};
            next_st.hi_on = 1'b0;
            next_st.lo_on = 1'b0;
            next_st.state = HS_FREE;
          end else begin
            next_st.word[15:8] = lk.bus8;
            next_st.hi_on      = 1'b0;
            next_st.lo_on      = 1'b1;
            next_st.state      = HS_LOW;
          end
        end
      end
      HS_LOW: begin
        if (st.cnt == aohp_pkg::DWELL_MIN - 6'h01) begin
          next_st.word[7:0] = lk.bus8;
          next_st.lo_on     = 1'b0;
          next_st.cnt       = 6'h00;
          next_st.state     = HS_FREE;
        end
      end
      HS_FREE: begin
        if (st.cnt == aohp_pkg::FREE_CYC - 6'h01) begin
          next_st.hold_n = 1'b1;
          next_st.valid  = 1'b1;
          next_st.cnt    = 6'h00;
          next_st.state  = HS_REFRESH;
        end
      end
      HS_REFRESH: begin
        // Lets the device latch refresh before the next hold
        if (st.cnt == aohp_pkg::HIGH_CYC - 6'h01) begin
          next_st.state = HS_IDLE;
          next_st.busy  = 1'b0;
        end
      end
      default: begin
        next_st.state = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st        <= '0;
      st.state  <= HS_IDLE;
      st.hold_n <= 1'b1;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign word_out               = st.word;
  assign word_valid_out         = st.valid;
  assign busy_out               = st.busy;
  assign lk.hold_output_latch_n = st.hold_n;
  assign lk.upper_en_drv        = !st.hi_on;
  assign lk.upper_en_oe         = st.hi_on;
  assign lk.lower_en_drv        = !st.lo_on;
  assign lk.lower_en_oe         = st.lo_on;

endmodule : aohp_host

// ===== bench/aohp_monitor.sv
// Link checker for the angle output hold port and its host
`timescale 1ns/100ps
module aohp_monitor (
  // Clock and reset
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  // Link signals
  input wire logic       hold_output_latch_n,
  input wire logic       upper_byte_enable_n,
  input wire logic       lower_byte_enable_n,
  input wire logic       update_pulse,
  input wire logic [7:0] upper_dat,
  input wire logic       upper_oe,
  input wire logic [7:0] lower_dat,
  input wire logic       lower_oe
);
  localparam int LEAD  = int'(aohp_pkg::LEAD_CYC);
  localparam int SETUP = int'(aohp_pkg::SETUP_CYC);
  localparam int HIGH  = int'(aohp_pkg::HIGH_CYC);
  localparam int PMIN  = int'(aohp_pkg::BUSY_CYC);
  // Longest legal pulse, 1.0 us
  localparam int PMAX  = int'($floor(aohp_pkg::BUSY_MAX_US * 1000.0 / aohp_pkg::CLK_PERIOD_NS));
  logic [5:0] low_cnt;
  logic [5:0] high_cnt;
  logic [5:0] busy_cnt;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      low_cnt  <= 6'h00;
      // Start as if idle for long, so the first read is not flagged
      high_cnt <= aohp_pkg::HIGH_CYC;
      busy_cnt <= 6'h00;
    end else begin
      low_cnt  <= hold_output_latch_n ? 6'h00 : low_cnt + 6'(low_cnt != 6'h3f);
      high_cnt <= hold_output_latch_n ? high_cnt + 6'(high_cnt != 6'h3f) : 6'h00;
      busy_cnt <= update_pulse ? busy_cnt + 6'(busy_cnt != 6'h3f) : 6'h00;
    end
  end
  sequence s_up_idle;
    !upper_oe && upper_dat == 8'h00;
  endsequence
  sequence s_lo_idle;
    !lower_oe && lower_dat == 8'h00;
  endsequence
  property p_up_drive;
    !upper_byte_enable_n |=> upper_oe;
  endproperty
  property p_up_release;
    upper_byte_enable_n |=> s_up_idle;
  endproperty
  property p_lo_drive;
    !lower_byte_enable_n |=> lower_oe;
  endproperty
  property p_lo_release;
    lower_byte_enable_n |=> s_lo_idle;
  endproperty
  property p_pulse_len;
    $fell(update_pulse) |-> busy_cnt >= PMIN && busy_cnt <= PMAX;
  endproperty
  property p_frozen;
    (!hold_output_latch_n && low_cnt >= SETUP && $stable(upper_oe) && $stable(lower_oe))
      |-> $stable(upper_dat) && $stable(lower_dat);
  endproperty
  property p_lead;
    ($fell(upper_byte_enable_n) || $fell(lower_byte_enable_n)) |-> !hold_output_latch_n && low_cnt >= LEAD;
  endproperty
  property p_setup;
    ($rose(upper_byte_enable_n) || $rose(lower_byte_enable_n)) |-> low_cnt >= SETUP;
  endproperty
  property p_hold_gap;
    $fell(hold_output_latch_n) |-> high_cnt >= HIGH;
  endproperty
  a_up_drive:   assert property (p_up_drive) else $error("upper lane not driven");
  a_up_release: assert property (p_up_release) else $error("upper lane not released");
  a_lo_drive:   assert property (p_lo_drive) else $error("lower lane not driven");
  a_lo_release: assert property (p_lo_release) else $error("lower lane not released");
  a_pulse_len:  assert property (p_pulse_len) else $error("update pulse length");
  a_frozen:     assert property (p_frozen) else $error("held word moved");
  a_lead:       assert property (p_lead) else $error("enable too early");
  a_setup:      assert property (p_setup) else $error("read before hold setup");
  a_hold_gap:   assert property (p_hold_gap) else $error("hold released too briefly");
endmodule : aohp_monitor

// ===== bench/angle_output_hold_port_bench.sv
// Self-checking bench joining the angle port to its host
`timescale 1ns/100ps
module angle_output_hold_port_bench;
  logic        core_clk_in;
  logic        rst_in;
  logic        step_req_in;
  logic        step_up_in;
  logic [1:0]  res_sel_in;
  logic        read_req_in;
  logic        bus16_in;
  logic [15:0] word_out;
  logic [15:0] angle_out;
  logic        word_valid_out;
  logic        busy_out;
  logic [1:0]  res_out;
  logic [15:0] cnt;
  logic [1:0]  res;
  logic [15:0] exp_q[$];
  int          miscompares;
  int          n_compared;
  integer      seed;
  int          i;
  int          mode;
  aohp_link_if lk ();
  aohp_port aohp_port_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1), .step_req_in(step_req_in),
    .step_up_in(step_up_in), .res_sel_in(res_sel_in), .angle_out(angle_out), .res_out(res_out), .lk(lk));
  aohp_host aohp_host_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1), .read_req_in(read_req_in),
    .bus16_in(bus16_in), .word_out(word_out), .word_valid_out(word_valid_out), .busy_out(busy_out), .lk(lk));
  aohp_monitor aohp_monitor_i (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .hold_output_latch_n(lk.hold_output_latch_n), .upper_byte_enable_n(lk.upper_byte_enable_n),
    .lower_byte_enable_n(lk.lower_byte_enable_n), .update_pulse(lk.update_pulse), .upper_dat(lk.upper_dat),
    .upper_oe(lk.upper_oe), .lower_dat(lk.lower_dat), .lower_oe(lk.lower_oe));
  function automatic logic [15:0] msk(input logic [1:0] r);
    return 16'hffff << (4'd6 - {r, 1'b0});
  endfunction : msk
  task chk(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : chk
  task complete_run;
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // Step size follows the resolution in force before the step
  task do_step;
    step_up_in <= 1'($random(seed));
    res_sel_in <= 2'($random(seed));
    step_req_in <= 1'b1;
    @(posedge core_clk_in);
    step_req_in <= 1'b0;
    cnt = step_up_in ? cnt + (16'h0001 << (4'd6 - {res, 1'b0})) : cnt - (16'h0001 << (4'd6 - {res, 1'b0}));
    res = res_sel_in;
  endtask : do_step
  task do_read;
    bus16_in <= 1'($random(seed));
    read_req_in <= 1'b1;
    @(posedge core_clk_in);
    read_req_in <= 1'b0;
  endtask : do_read
  task wait_idle;
    int k;
    @(posedge core_clk_in);
    for (k = 0; k < 300 && (busy_out !== 1'b0 || lk.update_pulse !== 1'b0); k++) begin
      @(posedge core_clk_in);
    end
    if (k == 300) begin
      miscompares++;
    end
  endtask : wait_idle
  always @(posedge core_clk_in) begin
    if ($rose(lk.upper_byte_enable_n) && exp_q.size() > 0) begin
      chk({8'h00, lk.upper_dat}, {8'h00, exp_q[0][15:8]});
    end
    if (word_valid_out === 1'b1) begin
      chk(word_out, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx);
    end
  end
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  // About 24 transfers of under 150 cycles each fit well inside this span
  initial begin
    #2000000;
    miscompares++;
    complete_run;
  end
  initial begin
    seed = 32'h4d8e_90b5;
    rst_in = 1'b1;
    step_req_in = 1'b0;
    step_up_in = 1'b0;
    res_sel_in = aohp_pkg::RES_RST;
    read_req_in = 1'b0;
    bus16_in = 1'b0;
    cnt = aohp_pkg::ANGLE_RST;
    res = aohp_pkg::RES_RST;
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    for (i = 0; i < 24; i++) begin
      mode = $unsigned($random(seed)) % 3;
      if (mode == 1) begin
        // Step lands while the word is held, so the old word is read
        exp_q.push_back(cnt & msk(res));
        do_read;
        repeat (3) @(posedge core_clk_in);
        do_step;
      end else begin
        do_step;
        if (mode == 2) begin
          @(posedge core_clk_in);
        end else begin
          wait_idle;
        end
        exp_q.push_back(cnt & msk(res));
        do_read;
      end
      wait_idle;
      chk({14'h0, res_out}, {14'h0, res});
      chk(angle_out, cnt);
    end
    complete_run;
  end
endmodule : angle_output_hold_port_bench
